// ==== core/video_ctrl_pkg.sv ====
// register map and constants for the video encoder control bank
package video_ctrl_pkg;
    localparam logic [7:0] mode3_addr = 8'h03;
    localparam logic [7:0] timing_addr = 8'h04;
    localparam logic [7:0] format_addr = 8'h05;
    localparam logic [7:0] pat_luma_addr = 8'h06;
    localparam logic [7:0] pat_red_addr = 8'h07;
    localparam logic [7:0] pat_blue_addr = 8'h08;
    localparam logic [7:0] pll_addr = 8'h09;
    localparam logic [7:0] gain_addr = 8'h10;
    localparam logic [7:0] cgms_low_addr = 8'h11;
    localparam logic [7:0] cgms_mid_addr = 8'h12;
    localparam logic [7:0] cgms_high_addr = 8'h13;
    localparam logic [7:0] gamma_base_addr = 8'h14;
    localparam logic [7:0] gamma_last_addr = 8'h21;
    localparam logic [7:0] mode1_addr = 8'h01;
    localparam logic [7:0] mode0_addr = 8'h00;
    localparam int gamma_points = 14;
    localparam int curve_points = 7;
    // bit positions in the dac/interpolation register, then the timing reset bit of the timing register
    localparam int second_dac_bit = 4;
    localparam int third_dac_bit = 5;
    localparam int interp_bit = 6;
    localparam int reserved_bit = 7;
    localparam int timing_reset_bit = 0;
    // bit positions in the format/gamma register; sharp_bit sits in the mode 1 register
    localparam int revision_bit = 0;
    localparam int rgb_bit = 1;
    localparam int sync_color_bit = 2;
    localparam int swap_bit = 3;
    localparam int curve_sel_bit = 4;
    localparam int gamma_en_bit = 5;
    localparam int adapt_mode_bit = 6;
    localparam int adapt_en_bit = 7;
    localparam int sharp_bit = 7;
    localparam int format_422_bit = 1;
    localparam logic [7:0] reg_reset = 8'h00;
    localparam logic [7:0] pll_recommended = 8'h3E;
    // revision code is arbitrary
    localparam logic revision_code = 1'b0;
    localparam logic [1:0] std_eia = 2'h0;
    localparam logic [1:0] std_full = 2'h2;
    localparam int clock_mhz = 125;
    localparam int interp_rate_mhz = 54;
    localparam logic [7:0] fixed_out_0 = 8'h00;
    localparam logic [7:0] fixed_out_16 = 8'h10;
    localparam logic [7:0] fixed_out_240 = 8'hF0;
    localparam logic [7:0] fixed_out_255 = 8'hFF;
endpackage

// ==== core/gamma_point_mem.sv ====
// fourteen-entry gamma point store with registered read
`timescale 1ns/100ps
module gamma_point_mem (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wr_en,
    input wire logic [3:0] wr_index,
    input wire logic [7:0] wr_data,
    input wire logic [3:0] rd_index,
    output logic [7:0] rd_data,
    input wire logic [3:0] lut_index_lo,
    input wire logic [3:0] lut_index_hi,
    output logic [7:0] lut_lo,
    output logic [7:0] lut_hi
);
    logic [7:0] mem [video_ctrl_pkg::gamma_points];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < video_ctrl_pkg::gamma_points; i++)
                mem[i] <= video_ctrl_pkg::reg_reset;
        end
        else if (wr_en)
            mem[wr_index] <= wr_data;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rd_data <= video_ctrl_pkg::reg_reset;
            lut_lo <= video_ctrl_pkg::reg_reset;
            lut_hi <= video_ctrl_pkg::reg_reset;
        end
        else
        begin
            rd_data <= mem[rd_index];
            lut_lo <= mem[lut_index_lo];
            lut_hi <= mem[lut_index_hi];
        end
    end
endmodule

// ==== core/video_encoder_control_regs.sv ====
// register bank and datapath controls of the progressive/hdtv encoder
// Operation
// - second and third dac run only while their enable bits are one
// - interpolation bit doubles converter sample rate through second filter stage
// - timing reset bit toggled high then low clears h and v counters
// - bit zero of format register returns revision code, not writable
// - rgb select treats inputs as unsigned rgb, also in async timing
// - sync on colour outputs only when enabled, standard 00 or 10, not rgb
// - second dac carries Pr, third Pb; swap bit exchanges them, rgb too
// - in 4:2:2 red port unused; shared port drives third dac
// - curve select zero picks first curve, one picks second
// - gamma enable applies selected curve, otherwise stage bypassed
// - adaptive mode select acts only with adaptive and sharpness enabled
// - adaptive filter needs its enable and sharpness enable both set
// - three 8-bit registers set luma, Cr, Cb of the test pattern
// - three cgms registers hold C0-C7, C8-C15 and C16-C19
// - gain low nibble is filter A gain, high nibble filter B gain
// - gamma changes luma only, colour differences pass untouched
// - fourteen gamma registers hold both curves, one curve used at a time
// - seven points spaced 32 from 32 to 224, linear between points
// - points at 0, 16, 240 and 255 are fixed
// - gain values act only while sharpness enable is one
// - second adaptive mode cascades A and B with both gains active
//
// Implementation choice: register access over APB.
`timescale 1ns/100ps
module video_encoder_control_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [9:0] luma_in,
    input wire logic [9:0] red_diff_pin_port,
    input wire logic [9:0] shared_chroma_pin_port,
    input wire logic input_422,
    input wire logic [1:0] output_standard_select,
    output logic [9:0] luma_out,
    output logic [9:0] second_dac_data,
    output logic [9:0] third_dac_data,
    output logic second_dac_power,
    output logic third_dac_power,
    output logic interpolation_active,
    output logic sync_on_color_active,
    output logic rgb_unsigned_mode,
    output logic [15:0] h_count,
    output logic [15:0] v_count,
    input wire logic [15:0] line_length,
    output logic [9:0] pattern_luma,
    output logic [9:0] pattern_red_diff,
    output logic [9:0] pattern_blue_diff,
    output logic [19:0] copy_mgmt_stream,
    output logic [3:0] gain_a_nibble,
    output logic [3:0] gain_b_nibble,
    output logic sharpness_active,
    output logic adaptive_active,
    output logic adaptive_cascade
);
    logic [7:0] dac_and_interp_control;
    logic [7:0] timing_reset_control;
    logic [7:0] format_and_gamma_control;
    logic [7:0] pattern_color_luma;
    logic [7:0] pattern_color_red_diff;
    logic [7:0] pattern_color_blue_diff;
    logic [7:0] pll_setup_value;
    logic [7:0] sharpness_gain_pair;
    logic [7:0] copy_mgmt_bits_low;
    logic [7:0] copy_mgmt_bits_mid;
    logic [7:0] copy_mgmt_bits_high;
    logic [7:0] filter_mode_control;
    logic [7:0] mode0_control;
    logic timing_reset_prev;
    logic access;
    logic wr;
    logic [7:0] word_addr;
    logic addr_ok;
    logic gamma_hit;
    logic [3:0] gamma_index;
    logic [7:0] gamma_rd;
    logic [7:0] next_rdata;
    logic rd_from_mem;
    logic [3:0] lut_lo_index;
    logic [3:0] lut_hi_index;
    logic [7:0] lut_lo;
    logic [7:0] lut_hi;
    logic [7:0] luma8;
    logic [7:0] seg_lo_val;
    logic [7:0] seg_hi_val;
    logic [4:0] seg_frac;
    logic [8:0] seg_frac_d;
    logic [3:0] seg_sel_d;
    logic [7:0] luma8_d;
    logic [9:0] chroma_b_d;
    logic [9:0] chroma_r_d;
    logic gamma_on_d;
    logic [7:0] next_gamma;
    logic [2:0] seg;

    // byte address in 32-bit words
    assign word_addr = paddr[9:2];
    assign access = psel && penable;
    assign wr = access && pwrite && pstrb[0];
    assign gamma_hit = word_addr >= video_ctrl_pkg::gamma_base_addr
        && word_addr <= video_ctrl_pkg::gamma_last_addr;
    assign gamma_index = 4'(word_addr - video_ctrl_pkg::gamma_base_addr);

    always_comb
    begin
        addr_ok = 1'b1;
        next_rdata = 8'h00;
        unique case (word_addr)
            video_ctrl_pkg::mode0_addr: next_rdata = mode0_control;
            video_ctrl_pkg::mode1_addr: next_rdata = filter_mode_control;
            video_ctrl_pkg::mode3_addr: next_rdata = dac_and_interp_control;
            video_ctrl_pkg::timing_addr: next_rdata = timing_reset_control;
            video_ctrl_pkg::format_addr: next_rdata = {format_and_gamma_control[7:1],
                video_ctrl_pkg::revision_code};
            video_ctrl_pkg::pat_luma_addr: next_rdata = pattern_color_luma;
            video_ctrl_pkg::pat_red_addr: next_rdata = pattern_color_red_diff;
            video_ctrl_pkg::pat_blue_addr: next_rdata = pattern_color_blue_diff;
            video_ctrl_pkg::pll_addr: next_rdata = pll_setup_value;
            video_ctrl_pkg::gain_addr: next_rdata = sharpness_gain_pair;
            video_ctrl_pkg::cgms_low_addr: next_rdata = copy_mgmt_bits_low;
            video_ctrl_pkg::cgms_mid_addr: next_rdata = copy_mgmt_bits_mid;
            video_ctrl_pkg::cgms_high_addr: next_rdata = {4'h0, copy_mgmt_bits_high[3:0]};
            default: addr_ok = gamma_hit;
        endcase
        if (paddr[31:10] != 22'h000000)
            addr_ok = 1'b0;
    end

    // gamma accesses wait a cycle for the registered memory read
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            rd_from_mem <= 1'b0;
        end
        else
        begin
            pready <= (psel && !penable && !(gamma_hit && addr_ok)) || (access && rd_from_mem);
            pslverr <= psel && !penable && !addr_ok;
            rd_from_mem <= psel && !penable && gamma_hit && addr_ok;
            if (psel && !penable)
                prdata <= addr_ok && !gamma_hit ? {24'h000000, next_rdata} : 32'h00000000;
            else if (access && rd_from_mem)
                prdata <= {24'h000000, gamma_rd};
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dac_and_interp_control <= video_ctrl_pkg::reg_reset;
            timing_reset_control <= video_ctrl_pkg::reg_reset;
            format_and_gamma_control <= video_ctrl_pkg::reg_reset;
            pattern_color_luma <= video_ctrl_pkg::reg_reset;
            pattern_color_red_diff <= video_ctrl_pkg::reg_reset;
            pattern_color_blue_diff <= video_ctrl_pkg::reg_reset;
            pll_setup_value <= video_ctrl_pkg::reg_reset;
            sharpness_gain_pair <= video_ctrl_pkg::reg_reset;
            copy_mgmt_bits_low <= video_ctrl_pkg::reg_reset;
            copy_mgmt_bits_mid <= video_ctrl_pkg::reg_reset;
            copy_mgmt_bits_high <= video_ctrl_pkg::reg_reset;
            filter_mode_control <= video_ctrl_pkg::reg_reset;
            mode0_control <= video_ctrl_pkg::reg_reset;
        end
        else if (wr && pready && !pslverr)
        begin
            unique case (word_addr)
                video_ctrl_pkg::mode0_addr: mode0_control <= pwdata[7:0];
                video_ctrl_pkg::mode1_addr: filter_mode_control <= pwdata[7:0];
                video_ctrl_pkg::mode3_addr: dac_and_interp_control <= pwdata[7:0];
                video_ctrl_pkg::timing_addr: timing_reset_control <= pwdata[7:0];
                video_ctrl_pkg::format_addr: format_and_gamma_control <= pwdata[7:0];
                video_ctrl_pkg::pat_luma_addr: pattern_color_luma <= pwdata[7:0];
                video_ctrl_pkg::pat_red_addr: pattern_color_red_diff <= pwdata[7:0];
                video_ctrl_pkg::pat_blue_addr: pattern_color_blue_diff <= pwdata[7:0];
                video_ctrl_pkg::pll_addr: pll_setup_value <= pwdata[7:0];
                video_ctrl_pkg::gain_addr: sharpness_gain_pair <= pwdata[7:0];
                video_ctrl_pkg::cgms_low_addr: copy_mgmt_bits_low <= pwdata[7:0];
                video_ctrl_pkg::cgms_mid_addr: copy_mgmt_bits_mid <= pwdata[7:0];
                video_ctrl_pkg::cgms_high_addr: copy_mgmt_bits_high <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    gamma_point_mem points (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(wr && pready && !pslverr && gamma_hit),
        .wr_index(gamma_index),
        .wr_data(pwdata[7:0]),
        .rd_index(gamma_index),
        .rd_data(gamma_rd),
        .lut_index_lo(lut_lo_index),
        .lut_index_hi(lut_hi_index),
        .lut_lo(lut_lo),
        .lut_hi(lut_hi)
    );

    // timing counters; cleared on the falling edge of the reset bit
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            timing_reset_prev <= 1'b0;
            h_count <= 16'h0000;
            v_count <= 16'h0000;
        end
        else
        begin
            timing_reset_prev <= timing_reset_control[video_ctrl_pkg::timing_reset_bit];
            if (timing_reset_prev && !timing_reset_control[video_ctrl_pkg::timing_reset_bit])
            begin
                h_count <= 16'h0000;
                v_count <= 16'h0000;
            end
            else if (h_count + 16'h0001 >= line_length)
            begin
                h_count <= 16'h0000;
                v_count <= v_count + 16'h0001;
            end
            else
                h_count <= h_count + 16'h0001;
        end
    end

    // gamma segment lookup: curve A entries 0..6, curve B entries 7..13
    assign luma8 = luma_in[9:2];
    always_comb
    begin
        seg = luma8[7:5];
        lut_lo_index = 4'h0;
        lut_hi_index = 4'h0;
        if (seg != 3'h0)
            lut_lo_index = 4'(seg - 3'h1);
        if (seg != 3'h7)
            lut_hi_index = 4'(seg);
        if (format_and_gamma_control[video_ctrl_pkg::curve_sel_bit])
        begin
            lut_lo_index = lut_lo_index + 4'(video_ctrl_pkg::curve_points);
            lut_hi_index = lut_hi_index + 4'(video_ctrl_pkg::curve_points);
        end
    end

    // stage one registers the segment while memory returns its two ends
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            luma8_d <= 8'h00;
            seg_sel_d <= 4'h0;
            seg_frac_d <= 9'h000;
            chroma_b_d <= 10'h000;
            chroma_r_d <= 10'h000;
            gamma_on_d <= 1'b0;
        end
        else
        begin
            luma8_d <= luma8;
            seg_sel_d <= {1'b0, luma8[7:5]};
            seg_frac_d <= {4'h0, luma8[4:0]};
            chroma_b_d <= shared_chroma_pin_port;
            chroma_r_d <= red_diff_pin_port;
            gamma_on_d <= format_and_gamma_control[video_ctrl_pkg::gamma_en_bit];
        end
    end

    // fixed ends: 0 maps 16..32 region from 16, top segment ends at 240 then 255
    always_comb
    begin
        seg_lo_val = seg_sel_d == 4'h0 ? video_ctrl_pkg::fixed_out_16 : lut_lo;
        seg_hi_val = seg_sel_d == 4'h7 ? video_ctrl_pkg::fixed_out_240 : lut_hi;
        seg_frac = seg_frac_d[4:0];
        next_gamma = 8'((({8'h00, seg_lo_val} * 16'(6'h20 - {1'b0, seg_frac}))
            + ({8'h00, seg_hi_val} * 16'(seg_frac))) >> 5);
        if (luma8_d < video_ctrl_pkg::fixed_out_16)
            next_gamma = luma8_d == 8'h00 ? video_ctrl_pkg::fixed_out_0
                : video_ctrl_pkg::fixed_out_16;
        else if (luma8_d >= video_ctrl_pkg::fixed_out_240)
            next_gamma = luma8_d == 8'hFF ? video_ctrl_pkg::fixed_out_255
                : video_ctrl_pkg::fixed_out_240;
    end

    // outputs: luma only through gamma, chroma delayed to stay aligned
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            luma_out <= 10'h000;
            second_dac_data <= 10'h000;
            third_dac_data <= 10'h000;
        end
        else
        begin
            luma_out <= gamma_on_d ? {next_gamma, 2'h0} : {luma8_d, 2'h0};
            if (input_422)
            begin
                second_dac_data <= 10'h000;
                third_dac_data <= chroma_b_d;
            end
            else if (format_and_gamma_control[video_ctrl_pkg::swap_bit])
            begin
                second_dac_data <= chroma_b_d;
                third_dac_data <= chroma_r_d;
            end
            else
            begin
                second_dac_data <= chroma_r_d;
                third_dac_data <= chroma_b_d;
            end
        end
    end

    // control outputs registered from the bank
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            second_dac_power <= 1'b0;
            third_dac_power <= 1'b0;
            interpolation_active <= 1'b0;
            sync_on_color_active <= 1'b0;
            rgb_unsigned_mode <= 1'b0;
            pattern_luma <= 10'h000;
            pattern_red_diff <= 10'h000;
            pattern_blue_diff <= 10'h000;
            copy_mgmt_stream <= 20'h00000;
            gain_a_nibble <= 4'h0;
            gain_b_nibble <= 4'h0;
            sharpness_active <= 1'b0;
            adaptive_active <= 1'b0;
            adaptive_cascade <= 1'b0;
        end
        else
        begin
            second_dac_power <= dac_and_interp_control[video_ctrl_pkg::second_dac_bit];
            third_dac_power <= dac_and_interp_control[video_ctrl_pkg::third_dac_bit];
            // enables 2x converter rate (interp_rate_mhz) in the analog stage
            interpolation_active <= dac_and_interp_control[video_ctrl_pkg::interp_bit];
            rgb_unsigned_mode <= format_and_gamma_control[video_ctrl_pkg::rgb_bit];
            sync_on_color_active <= format_and_gamma_control[video_ctrl_pkg::sync_color_bit]
                && !format_and_gamma_control[video_ctrl_pkg::rgb_bit]
                && (output_standard_select == video_ctrl_pkg::std_eia
                || output_standard_select == video_ctrl_pkg::std_full);
            pattern_luma <= {pattern_color_luma, 2'h0};
            pattern_red_diff <= {pattern_color_red_diff, 2'h0};
            pattern_blue_diff <= {pattern_color_blue_diff, 2'h0};
            copy_mgmt_stream <= {copy_mgmt_bits_high[3:0], copy_mgmt_bits_mid,
                copy_mgmt_bits_low};
            sharpness_active <= filter_mode_control[video_ctrl_pkg::sharp_bit];
            gain_a_nibble <= filter_mode_control[video_ctrl_pkg::sharp_bit]
                ? sharpness_gain_pair[3:0] : 4'h0;
            gain_b_nibble <= filter_mode_control[video_ctrl_pkg::sharp_bit]
                ? sharpness_gain_pair[7:4] : 4'h0;
            adaptive_active <= filter_mode_control[video_ctrl_pkg::sharp_bit]
                && format_and_gamma_control[video_ctrl_pkg::adapt_en_bit];
            adaptive_cascade <= filter_mode_control[video_ctrl_pkg::sharp_bit]
                && format_and_gamma_control[video_ctrl_pkg::adapt_en_bit]
                && format_and_gamma_control[video_ctrl_pkg::adapt_mode_bit];
        end
    end
endmodule

// ==== tb/video_encoder_control_regs_properties.sv ====
// concurrent checks on the ports of the encoder control bank
`timescale 1ns/100ps
module video_encoder_control_regs_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic second_dac_power,
    input wire logic interpolation_active,
    input wire logic sync_on_color_active,
    input wire logic rgb_unsigned_mode,
    input wire logic [15:0] h_count,
    input wire logic [15:0] v_count,
    input wire logic [9:0] pattern_luma,
    input wire logic [19:0] copy_mgmt_stream,
    input wire logic [3:0] gain_a_nibble,
    input wire logic [3:0] gain_b_nibble,
    input wire logic sharpness_active,
    input wire logic adaptive_active
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire acc = psel && penable && pready;
    wire wr = acc && pwrite && pstrb[0];
    wire [7:0] idx = paddr[9:2];
    sequence raise_timing;
        wr && idx == 8'h04 && pwdata[0];
    endsequence
    sequence drop_timing;
        wr && idx == 8'h04 && !pwdata[0];
    endsequence
    AST_DAC_POWER: assert property (
        wr && idx == 8'h03 |-> ##2 second_dac_power == $past(pwdata[4], 2))
        else $error("dac power differs from its enable bit");
    AST_INTERP: assert property (
        wr && idx == 8'h03 |-> ##2 interpolation_active == $past(pwdata[6], 2))
        else $error("interpolation differs from its enable bit");
    AST_TIMING_CLEAR: assert property (
        raise_timing ##[2:40] drop_timing |-> ##[1:4] h_count == 16'h0000 && v_count == 16'h0000)
        else $error("timing counters not cleared");
    AST_REVISION: assert property (
        acc && !pwrite && idx == 8'h05 |-> prdata[0] == video_ctrl_pkg::revision_code)
        else $error("revision bit reads wrong");
    AST_SYNC_RGB: assert property (
        sync_on_color_active |-> !rgb_unsigned_mode)
        else $error("sync on colour active in rgb mode");
    AST_ADAPT: assert property (
        adaptive_active |-> sharpness_active)
        else $error("adaptive active without sharpness");
    AST_CGMS: assert property (
        wr && idx == 8'h13 |-> ##2 copy_mgmt_stream[19:16] == $past(pwdata[3:0], 2))
        else $error("cgms top nibble wrong");
    AST_GAIN_GATE: assert property (
        !sharpness_active |-> gain_a_nibble == 4'h0 && gain_b_nibble == 4'h0)
        else $error("gain active without sharpness");
    AST_PATTERN: assert property (
        wr && idx == 8'h06 |-> ##2 pattern_luma == {$past(pwdata[7:0], 2), 2'b00})
        else $error("pattern luma not widened");
    AST_BAD_ADDR: assert property (
        acc && idx == 8'h02 |-> pslverr)
        else $error("unmapped access not refused");
endmodule
bind video_encoder_control_regs video_encoder_control_regs_checker checker_i (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .second_dac_power, .interpolation_active, .sync_on_color_active, .rgb_unsigned_mode,
    .h_count, .v_count, .pattern_luma, .copy_mgmt_stream, .gain_a_nibble, .gain_b_nibble,
    .sharpness_active, .adaptive_active);

// ==== tb/video_encoder_control_regs_tb_top.sv ====
// self-checking bench for the encoder control bank
`timescale 1ns/100ps
module video_encoder_control_regs_tb_top;
    logic pclk, presetn, psel, penable, pwrite, input_422, pready, pslverr, serr;
    logic [31:0] paddr, pwdata, prdata, rdat;
    logic [3:0] pstrb, gain_a_nibble, gain_b_nibble;
    logic second_dac_power, third_dac_power, interpolation_active, sync_on_color_active;
    logic rgb_unsigned_mode, sharpness_active, adaptive_active, adaptive_cascade;
    logic [9:0] luma_in, red_diff_pin_port, shared_chroma_pin_port, luma_out, second_dac_data;
    logic [9:0] third_dac_data, pattern_luma, pattern_red_diff, pattern_blue_diff;
    logic [1:0] output_standard_select;
    logic [15:0] h_count, v_count, line_length;
    logic [19:0] copy_mgmt_stream;
    int n_errors = 0;
    int checked = 0;
    // idx, write, readback
    localparam logic [23:0] rows [15] = '{24'h093E3E, 24'h06EBEB, 24'h07F0F0, 24'h085A5A,
        24'h037070, 24'h109B9B, 24'h115A5A, 24'h12C3C3, 24'h13A707, 24'h144040,
        24'h156060, 24'h179393, 24'h1E4040, 24'h217777, 24'h050100};
    video_encoder_control_regs video_encoder_control_regs_i (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .luma_in,
        .red_diff_pin_port, .shared_chroma_pin_port, .input_422, .output_standard_select,
        .luma_out, .second_dac_data, .third_dac_data, .second_dac_power, .third_dac_power,
        .interpolation_active, .sync_on_color_active, .rgb_unsigned_mode, .h_count, .v_count,
        .line_length, .pattern_luma, .pattern_red_diff, .pattern_blue_diff, .copy_mgmt_stream,
        .gain_a_nibble, .gain_b_nibble, .sharpness_active, .adaptive_active, .adaptive_cascade);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // entered just after a rising edge; one idle edge at the end keeps drives apart
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {22'h0, idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rdat = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        apb(1'b1, idx, wd);
        repeat (2) @(posedge pclk);
    endtask
    task automatic stream(input logic [7:0] fmt, input logic [9:0] lin, input logic i422,
        input logic [29:0] expv);
        luma_in <= lin;
        input_422 <= i422;
        wr(8'h05, fmt);
        @(posedge pclk);
        chk(32'({luma_out, second_dac_data, third_dac_data}), 32'(expv));
    endtask
    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    initial
    begin
        repeat (5000) @(posedge pclk);
        n_errors++;
        print_verdict();
    end
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        pstrb = 4'hF;
        luma_in = 10'h0;
        red_diff_pin_port = 10'h111;
        shared_chroma_pin_port = 10'h222;
        input_422 = 1'b0;
        output_standard_select = 2'h0;
        line_length = 16'h0020;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (rows[i])
        begin
            apb(1'b1, rows[i][23:16], rows[i][15:8]);
            apb(1'b0, rows[i][23:16], 8'h00);
            chk(rdat, {24'h0, rows[i][7:0]});
        end
        chk(32'({second_dac_power, third_dac_power, interpolation_active}), 32'h7);
        chk(32'({pattern_luma, pattern_red_diff, pattern_blue_diff}), 32'h3ACF0168);
        chk(32'(copy_mgmt_stream), 32'h7C35A);
        chk(32'({gain_b_nibble, gain_a_nibble}), 32'h0);
        $display("test table done");
        wr(8'h03, 8'h20);
        chk(32'({second_dac_power, third_dac_power, interpolation_active}), 32'h2);
        for (int s = 0; s < 4; s++)
        begin
            output_standard_select <= 2'(s);
            wr(8'h05, 8'h04);
            chk(32'(sync_on_color_active), 32'(s % 2 == 0));
        end
        wr(8'h05, 8'h06);
        chk(32'({sync_on_color_active, rgb_unsigned_mode}), 32'h1);
        wr(8'h01, 8'h80);
        chk(32'({gain_b_nibble, gain_a_nibble, adaptive_active}), 32'h136);
        wr(8'h05, 8'h80);
        chk(32'({adaptive_active, adaptive_cascade}), 32'h2);
        wr(8'h05, 8'hC0);
        chk(32'({adaptive_active, adaptive_cascade}), 32'h3);
        $display("test controls done");
        stream(8'h20, 10'h0C0, 1'b0, {10'h140, 10'h111, 10'h222});
        stream(8'h20, 10'h200, 1'b0, {10'h24C, 10'h111, 10'h222});
        stream(8'h30, 10'h200, 1'b0, {10'h100, 10'h111, 10'h222});
        stream(8'h00, 10'h200, 1'b0, {10'h200, 10'h111, 10'h222});
        stream(8'h20, 10'h3FC, 1'b0, {10'h3FC, 10'h111, 10'h222});
        stream(8'h08, 10'h200, 1'b0, {10'h200, 10'h222, 10'h111});
        stream(8'h08, 10'h200, 1'b1, {10'h200, 10'h000, 10'h222});
        $display("test stream done");
        apb(1'b1, 8'h02, 8'h55);
        chk(32'(serr), 32'h1);
        apb(1'b0, 8'h22, 8'h00);
        chk({serr, rdat[30:0]}, 32'h80000000);
        chk(32'(v_count != 16'h0), 32'h1);
        wr(8'h04, 8'h01);
        wr(8'h04, 8'h00);
        chk(32'({v_count, h_count[15:3]}), 32'h0);
        $display("test refusal done");
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(32'({interpolation_active, sharpness_active, copy_mgmt_stream}), 32'h0);
        apb(1'b0, 8'h10, 8'h00);
        chk(rdat, 32'h0);
        $display("test reset done");
        print_verdict();
    end
endmodule
